/* verilog/nbp_pkg.sv */
package nbp_pkg;
   // Widths and depths.
   localparam int ADDR_W = 25;
   localparam int DQ_W = 16;
   localparam int PADDR_W = 8;
   localparam int PWD_DEPTH = 8;
   // Register offsets.
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_ADDR = 8'h04;
   localparam logic [7:0] OFF_DATA = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_RDATA = 8'h10;
   localparam logic [7:0] OFF_PWD = 8'h20;
   localparam logic [7:0] OFF_PWD_END = 8'h3C;
   // Field positions.
   localparam int CTRL_CMD_LSB = 0;
   localparam int CTRL_WORD_BIT = 4;
   localparam int CTRL_GO_BIT = 8;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_ERR_BIT = 2;
   localparam int ST_PROT_BIT = 3;
   // Reset values.
   localparam logic [31:0] RST_REG = 32'h0000_0000;
   localparam logic [3:0] RST_CMD = 4'h0;
   // Flash addresses and data codes.
   localparam logic [ADDR_W-1:0] A_BYTE_U1 = 25'h000_0AAA;
   localparam logic [ADDR_W-1:0] A_BYTE_U2 = 25'h000_0555;
   localparam logic [ADDR_W-1:0] A_WORD_U1 = 25'h000_0555;
   localparam logic [ADDR_W-1:0] A_WORD_U2 = 25'h000_02AA;
   localparam logic [7:0] D_UNLOCK1 = 8'hAA;
   localparam logic [7:0] D_UNLOCK2 = 8'h55;
   localparam logic [7:0] CODE_LOCK = 8'h40;
   localparam logic [7:0] CODE_PWD = 8'h60;
   localparam logic [7:0] CODE_NV = 8'hC0;
   localparam logic [7:0] CODE_LKB = 8'h50;
   localparam logic [7:0] CODE_VOL = 8'hE0;
   localparam logic [7:0] CODE_EXT = 8'h88;
   localparam logic [7:0] D_EXIT1 = 8'h90;
   localparam logic [7:0] D_EXIT2 = 8'h00;
   localparam logic [7:0] D_PROG = 8'hA0;
   localparam logic [7:0] D_CLR1 = 8'h80;
   localparam logic [7:0] D_CLR2 = 8'h30;
   localparam logic [7:0] D_PW1 = 8'h25;
   localparam logic [7:0] D_PW2 = 8'h03;
   localparam logic [7:0] D_PW3 = 8'h29;
   localparam logic [7:0] D_PROT = 8'h00;
   // Timing.
   localparam int CLK_MHZ = 10;
   localparam int SPACE_NS = 1000;
   localparam int SPACE_CYC = (SPACE_NS * CLK_MHZ + 999) / 1000;
   localparam int ACC_NS = 80;
   localparam int ACC_CYC = (ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int WP_NS = 50;
   localparam int WP_CYC = (WP_NS * CLK_MHZ + 999) / 1000;
   localparam int SYNC_STAGES = 2;
   typedef enum logic [3:0] {
      CMD_ENTER_LOCK, CMD_ENTER_PWD, CMD_ENTER_NV, CMD_ENTER_LKB,
      CMD_ENTER_VOL, CMD_ENTER_EXT, CMD_EXIT_PROT, CMD_EXIT_EXT,
      CMD_PROGRAM, CMD_READ, CMD_CLEAR_NV, CMD_UNLOCK
   } nbp_cmd_t;
   typedef struct packed {
      logic last;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0] data;
   } nbp_step_t;
endpackage : nbp_pkg

/* verilog/nbp_cyc_if.sv */
`timescale 1ns/1ps
interface nbp_cyc_if;
   logic req;
   logic rd;
   logic [nbp_pkg::ADDR_W-1:0] addr;
   logic [nbp_pkg::DQ_W-1:0] wdata;
   logic ack;
   logic [nbp_pkg::DQ_W-1:0] rdata;
   modport ctl (output req, rd, addr, wdata, input ack, rdata);
   modport eng (input req, rd, addr, wdata, output ack, rdata);
endinterface : nbp_cyc_if

/* verilog/nbp_pwd_mem.sv */
`timescale 1ns/1ps
module nbp_pwd_mem #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 16,
   parameter int AW = $clog2(DEPTH)
) (
   // Clock, reset and enable
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   // Write port
   input wire logic wr_en_in,
   input wire logic [AW-1:0] waddr_in,
   input wire logic [WIDTH-1:0] wdata_in,
   // Read port
   input wire logic [AW-1:0] raddr_in,
   output logic [WIDTH-1:0] rdata_out
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] next_rdata;
   always_comb begin
      next_rdata = mem[raddr_in];
   end
   always_ff @(posedge sys_clk_in) begin
      if (ce_in && wr_en_in) begin
         mem[waddr_in] <= wdata_in;
      end
   end
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_out <= '0;
      end else if (ce_in) begin
         rdata_out <= next_rdata;
      end
   end
endmodule : nbp_pwd_mem

/* verilog/nbp_cycle.sv */
`timescale 1ns/1ps
module nbp_cycle (
   // Clock, reset and enable
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   // Cycle requests
   nbp_cyc_if.eng cyc,
   // Flash pins
   output logic ce_n_out,
   output logic oe_n_out,
   output logic we_n_out,
   output logic [nbp_pkg::ADDR_W-1:0] addr_out,
   output logic [nbp_pkg::DQ_W-1:0] dq_out,
   output logic dq_oe_out,
   input wire logic [nbp_pkg::DQ_W-1:0] dq_in
);
   localparam logic [2:0] RD_LIM =
      3'(nbp_pkg::ACC_CYC + nbp_pkg::SYNC_STAGES - 1);
   localparam logic [2:0] WR_LIM = 3'(nbp_pkg::WP_CYC - 1);
   typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_RECOVER} nbp_cst_t;
   nbp_cst_t state, next_state;
   logic [2:0] cnt, next_cnt;
   logic rd, next_rd, ack, next_ack;
   logic next_ce_n, next_oe_n, next_we_n, next_dq_oe;
   logic [nbp_pkg::ADDR_W-1:0] next_addr;
   logic [nbp_pkg::DQ_W-1:0] next_dq, rdata, next_rdata, dq_s1, dq_s2;
   assign cyc.ack = ack;
   assign cyc.rdata = rdata;
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         dq_s1 <= '0;
         dq_s2 <= '0;
      end else if (ce_in) begin
         dq_s1 <= dq_in;
         dq_s2 <= dq_s1;
      end
   end
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_rd = rd;
      next_ack = 1'b0;
      next_ce_n = ce_n_out;
      next_oe_n = oe_n_out;
      next_we_n = we_n_out;
      next_dq_oe = dq_oe_out;
      next_addr = addr_out;
      next_dq = dq_out;
      next_rdata = rdata;
      case (state)
         C_IDLE: begin
            next_dq_oe = 1'b0;
            if (cyc.req) begin
               next_addr = cyc.addr;
               next_dq = cyc.wdata;
               next_rd = cyc.rd;
               next_dq_oe = !cyc.rd;
               next_ce_n = 1'b0;
               next_state = C_SETUP;
            end
         end
         C_SETUP: begin
            next_cnt = 3'd0;
            next_oe_n = !rd;
            next_we_n = rd;
            next_state = C_STROBE;
         end
         C_STROBE: begin
            if (cnt == (rd ? RD_LIM : WR_LIM)) begin
               next_oe_n = 1'b1;
               next_we_n = 1'b1;
               if (rd) begin
                  next_rdata = dq_s2;
               end
               next_state = C_RECOVER;
            end else begin
               next_cnt = cnt + 3'd1;
            end
         end
         default: begin
            next_ce_n = 1'b1;
            next_ack = 1'b1;
            next_state = C_IDLE;
         end
      endcase
   end
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= C_IDLE;
         cnt <= 3'd0;
         rd <= 1'b0;
         ack <= 1'b0;
         ce_n_out <= 1'b1;
         oe_n_out <= 1'b1;
         we_n_out <= 1'b1;
         dq_oe_out <= 1'b0;
         addr_out <= '0;
         dq_out <= '0;
         rdata <= '0;
      end else if (ce_in) begin
         state <= next_state;
         cnt <= next_cnt;
         rd <= next_rd;
         ack <= next_ack;
         ce_n_out <= next_ce_n;
         oe_n_out <= next_oe_n;
         we_n_out <= next_we_n;
         dq_oe_out <= next_dq_oe;
         addr_out <= next_addr;
         dq_out <= next_dq;
         rdata <= next_rdata;
      end
   end
endmodule : nbp_cycle

/* verilog/nbp_host_top.sv */
`timescale 1ns/1ps
module nbp_host_top (
   // Clock, reset and enable
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [nbp_pkg::PADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Flash pins
   output logic flash_ce_n_out,
   output logic flash_oe_n_out,
   output logic flash_we_n_out,
   output logic flash_byte_n_out,
   output logic [nbp_pkg::ADDR_W-1:0] flash_addr_out,
   output logic [nbp_pkg::DQ_W-1:0] flash_dq_out,
   output logic flash_dq_oe_out,
   input wire logic [nbp_pkg::DQ_W-1:0] flash_dq_in
);
   localparam int SPACE_W = $clog2(nbp_pkg::SPACE_CYC + 1);
   localparam logic [SPACE_W-1:0] SPACE_LOAD = SPACE_W'(nbp_pkg::SPACE_CYC);
   localparam int PW_AW = $clog2(nbp_pkg::PWD_DEPTH);
   localparam int AW = nbp_pkg::ADDR_W;
   localparam int DW = nbp_pkg::DQ_W;

   typedef enum logic [1:0] {S_IDLE, S_PREP, S_LOAD, S_WAIT} nbp_seq_t;

   nbp_cyc_if cyc ();

   // APB group.
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   // Core group.
   nbp_seq_t state, next_state;
   nbp_pkg::nbp_cmd_t cmd, next_cmd;
   logic [3:0] step, next_step;
   logic [SPACE_W-1:0] space_cnt, next_space_cnt;
   logic next_byte_n;
   logic [AW-1:0] tgt_addr, next_tgt_addr;
   logic [DW-1:0] wr_data, next_wr_data, rd_data, next_rd_data;
   logic done, next_done, err, next_err, prot, next_prot;
   logic req, next_req, req_rd, next_req_rd;
   logic [AW-1:0] req_addr, next_req_addr;
   logic [DW-1:0] req_data, next_req_data;
   // Decode helpers.
   logic wr_fire, go, busy, pw_wr;
   logic [DW-1:0] pw_rdata;
   logic [PW_AW-1:0] pw_raddr;
   nbp_pkg::nbp_cmd_t new_cmd;
   nbp_pkg::nbp_step_t cur;

   function automatic logic is_pwd(input logic [nbp_pkg::PADDR_W-1:0] a);
      is_pwd = (a >= nbp_pkg::OFF_PWD) && (a <= nbp_pkg::OFF_PWD_END) &&
               (a[1:0] == 2'b00);
   endfunction : is_pwd

   function automatic logic [7:0] set_code(input nbp_pkg::nbp_cmd_t c);
      case (c)
         nbp_pkg::CMD_ENTER_LOCK: set_code = nbp_pkg::CODE_LOCK;
         nbp_pkg::CMD_ENTER_PWD: set_code = nbp_pkg::CODE_PWD;
         nbp_pkg::CMD_ENTER_NV: set_code = nbp_pkg::CODE_NV;
         nbp_pkg::CMD_ENTER_LKB: set_code = nbp_pkg::CODE_LKB;
         nbp_pkg::CMD_ENTER_VOL: set_code = nbp_pkg::CODE_VOL;
         nbp_pkg::CMD_ENTER_EXT: set_code = nbp_pkg::CODE_EXT;
         default: set_code = nbp_pkg::D_EXIT1;
      endcase
   endfunction : set_code

   // Builds bus cycle s of command c.
   function automatic nbp_pkg::nbp_step_t step_fn(
      input nbp_pkg::nbp_cmd_t c,
      input logic [3:0] s,
      input logic w,
      input logic [AW-1:0] a,
      input logic [DW-1:0] d,
      input logic [DW-1:0] pw
   );
      nbp_pkg::nbp_step_t r;
      logic [AW-1:0] u1;
      logic [AW-1:0] u2;
      logic [3:0] npw;
      logic [DW-1:0] dm;
      logic [DW-1:0] pm;
      r = '0;
      u1 = w ? nbp_pkg::A_WORD_U1 : nbp_pkg::A_BYTE_U1;
      u2 = w ? nbp_pkg::A_WORD_U2 : nbp_pkg::A_BYTE_U2;
      npw = w ? 4'd4 : 4'd8;
      dm = w ? d : {8'h00, d[7:0]};
      pm = w ? pw : {8'h00, pw[7:0]};
      case (c)
         nbp_pkg::CMD_EXIT_PROT: begin
            r.data = {8'h00, (s == 4'd0) ? nbp_pkg::D_EXIT1
                                          : nbp_pkg::D_EXIT2};
            r.last = (s != 4'd0);
         end
         nbp_pkg::CMD_PROGRAM: begin
            // Second cycle carries target address and data.
            r.addr = (s == 4'd0) ? '0 : a;
            r.data = (s == 4'd0) ? {8'h00, nbp_pkg::D_PROG}
                                 : dm;
            r.last = (s != 4'd0);
         end
         nbp_pkg::CMD_CLEAR_NV: begin
            r.data = {8'h00, (s == 4'd0) ? nbp_pkg::D_CLR1
                                          : nbp_pkg::D_CLR2};
            r.last = (s != 4'd0);
         end
         nbp_pkg::CMD_READ: begin
            // A plain read at the given address, no command code.
            r.rd = 1'b1;
            r.addr = a;
            r.last = 1'b1;
         end
         nbp_pkg::CMD_UNLOCK: begin
            if (s == 4'd0) begin
               r.data = {8'h00, nbp_pkg::D_PW1};
            end else if (s == 4'd1) begin
               r.data = {8'h00, nbp_pkg::D_PW2};
            end else if (s < npw + 4'd2) begin
               r.addr = {{(AW - 4){1'b0}}, s - 4'd2};
               r.data = pm;
            end else begin
               r.data = {8'h00, nbp_pkg::D_PW3};
               r.last = 1'b1;
            end
         end
         default: begin
            // Entry sequences and the extended block exit.
            r.addr = (s == 4'd1) ? u2 : u1;
            if (s == 4'd0) begin
               r.data = {8'h00, nbp_pkg::D_UNLOCK1};
            end else if (s == 4'd1) begin
               r.data = {8'h00, nbp_pkg::D_UNLOCK2};
            end else if (s == 4'd2) begin
               r.data = {8'h00, set_code(c)};
               r.last = (c != nbp_pkg::CMD_EXIT_EXT);
            end else begin
               r.addr = '0;
               r.data = {8'h00, nbp_pkg::D_EXIT2};
               r.last = 1'b1;
            end
         end
      endcase
      return r;
   endfunction : step_fn

   assign cyc.req = req;
   assign cyc.rd = req_rd;
   assign cyc.addr = req_addr;
   assign cyc.wdata = req_data;

   assign busy = (state != S_IDLE);
   assign wr_fire = psel_in && penable_in && pwrite_in && pready_out &&
                    !pslverr_out;
   assign go = wr_fire && (paddr_in == nbp_pkg::OFF_CTRL) &&
               pwdata_in[nbp_pkg::CTRL_GO_BIT];
   assign new_cmd = nbp_pkg::nbp_cmd_t'(pwdata_in[nbp_pkg::CTRL_CMD_LSB +: 4]);
   assign pw_wr = wr_fire && is_pwd(paddr_in) && !busy;
   assign pw_raddr = PW_AW'(step - 4'd2);
   assign cur = step_fn(cmd, step, !flash_byte_n_out, tgt_addr, wr_data,
                        pw_rdata);

   nbp_pwd_mem #(
      .DEPTH(nbp_pkg::PWD_DEPTH),
      .WIDTH(DW)
   ) u_pwd (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .ce_in(ce_in),
      .wr_en_in(pw_wr),
      .waddr_in(paddr_in[PW_AW+1:2]),
      .wdata_in(pwdata_in[DW-1:0]),
      .raddr_in(pw_raddr),
      .rdata_out(pw_rdata)
   );

   nbp_cycle u_cycle (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .ce_in(ce_in),
      .cyc(cyc.eng),
      .ce_n_out(flash_ce_n_out),
      .oe_n_out(flash_oe_n_out),
      .we_n_out(flash_we_n_out),
      .addr_out(flash_addr_out),
      .dq_out(flash_dq_out),
      .dq_oe_out(flash_dq_oe_out),
      .dq_in(flash_dq_in)
   );

   // APB slave with one wait state.
   always_comb begin
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_prdata = prdata_out;
      if (psel_in && penable_in && !pready_out) begin
         next_pready = 1'b1;
         next_prdata = nbp_pkg::RST_REG;
         if (paddr_in == nbp_pkg::OFF_CTRL) begin
            next_prdata[nbp_pkg::CTRL_CMD_LSB +: 4] = cmd;
            next_prdata[nbp_pkg::CTRL_WORD_BIT] = !flash_byte_n_out;
         end else if (paddr_in == nbp_pkg::OFF_ADDR) begin
            next_prdata[AW-1:0] = tgt_addr;
         end else if (paddr_in == nbp_pkg::OFF_DATA) begin
            next_prdata[DW-1:0] = wr_data;
         end else if (paddr_in == nbp_pkg::OFF_STATUS) begin
            next_prdata[nbp_pkg::ST_BUSY_BIT] = busy;
            next_prdata[nbp_pkg::ST_DONE_BIT] = done;
            next_prdata[nbp_pkg::ST_ERR_BIT] = err;
            next_prdata[nbp_pkg::ST_PROT_BIT] = prot;
         end else if (paddr_in == nbp_pkg::OFF_RDATA) begin
            next_prdata[DW-1:0] = rd_data;
         end else if (is_pwd(paddr_in)) begin
            next_prdata = nbp_pkg::RST_REG;
         end else begin
            next_pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         prdata_out <= nbp_pkg::RST_REG;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end else if (ce_in) begin
         prdata_out <= next_prdata;
         pready_out <= next_pready;
         pslverr_out <= next_pslverr;
      end
   end

   // Register writes and the command sequencer.
   always_comb begin
      next_state = state;
      next_cmd = cmd;
      next_step = step;
      next_space_cnt = space_cnt;
      next_byte_n = flash_byte_n_out;
      next_tgt_addr = tgt_addr;
      next_wr_data = wr_data;
      next_rd_data = rd_data;
      next_done = done;
      next_err = err;
      next_prot = prot;
      next_req = 1'b0;
      next_req_rd = req_rd;
      next_req_addr = req_addr;
      next_req_data = req_data;
      if (space_cnt != '0) begin
         next_space_cnt = space_cnt - 1'b1;
      end
      if (wr_fire && (paddr_in == nbp_pkg::OFF_STATUS)) begin
         if (pwdata_in[nbp_pkg::ST_DONE_BIT]) begin
            next_done = 1'b0;
         end
         if (pwdata_in[nbp_pkg::ST_ERR_BIT]) begin
            next_err = 1'b0;
         end
      end
      if (wr_fire && !busy) begin
         if (paddr_in == nbp_pkg::OFF_ADDR) begin
            next_tgt_addr = pwdata_in[AW-1:0];
         end else if (paddr_in == nbp_pkg::OFF_DATA) begin
            next_wr_data = pwdata_in[DW-1:0];
         end
      end
      if (go) begin
         if (busy || (pwdata_in[nbp_pkg::CTRL_CMD_LSB +: 4] >
                      4'(nbp_pkg::CMD_UNLOCK))) begin
            next_err = 1'b1;
         end else if ((new_cmd == nbp_pkg::CMD_UNLOCK) &&
                      (space_cnt != '0)) begin
            next_err = 1'b1;
         end else begin
            next_cmd = new_cmd;
            next_byte_n = !pwdata_in[nbp_pkg::CTRL_WORD_BIT];
            next_step = 4'd0;
            next_state = S_PREP;
         end
      end
      case (state)
         S_PREP: begin
            next_state = S_LOAD;
         end
         S_LOAD: begin
            next_req = 1'b1;
            next_req_rd = cur.rd;
            next_req_addr = cur.addr;
            next_req_data = cur.data;
            next_state = S_WAIT;
         end
         S_WAIT: begin
            if (cyc.ack) begin
               if (req_rd) begin
                  next_rd_data = cyc.rdata;
                  next_prot = (cyc.rdata[7:0] == nbp_pkg::D_PROT);
               end
               if (cur.last) begin
                  next_done = 1'b1;
                  next_state = S_IDLE;
                  if (cmd == nbp_pkg::CMD_UNLOCK) begin
                     next_space_cnt = SPACE_LOAD;
                  end
               end else begin
                  next_step = step + 4'd1;
                  next_state = S_PREP;
               end
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= S_IDLE;
         cmd <= nbp_pkg::nbp_cmd_t'(nbp_pkg::RST_CMD);
         step <= 4'd0;
         space_cnt <= '0;
         flash_byte_n_out <= 1'b1;
         tgt_addr <= '0;
         wr_data <= '0;
         rd_data <= '0;
         done <= 1'b0;
         err <= 1'b0;
         prot <= 1'b0;
         req <= 1'b0;
         req_rd <= 1'b0;
         req_addr <= '0;
         req_data <= '0;
      end else if (ce_in) begin
         state <= next_state;
         cmd <= next_cmd;
         step <= next_step;
         space_cnt <= next_space_cnt;
         flash_byte_n_out <= next_byte_n;
         tgt_addr <= next_tgt_addr;
         wr_data <= next_wr_data;
         rd_data <= next_rd_data;
         done <= next_done;
         err <= next_err;
         prot <= next_prot;
         req <= next_req;
         req_rd <= next_req_rd;
         req_addr <= next_req_addr;
         req_data <= next_req_data;
      end
   end
endmodule : nbp_host_top

/* dv/nbp_host_sva.sv */
`timescale 1ns/1ps
module nbp_host_sva (
   // Clock, reset and bus
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // Flash pins
   input wire logic flash_ce_n_out,
   input wire logic flash_oe_n_out,
   input wire logic flash_we_n_out,
   input wire logic flash_byte_n_out,
   input wire logic [nbp_pkg::ADDR_W-1:0] flash_addr_out,
   input wire logic [nbp_pkg::DQ_W-1:0] flash_dq_out,
   input wire logic flash_dq_oe_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);
   a_apb_wait: assert property (psel_in && $rose(penable_in) |=> pready_out)
      else $error("pready late");
   a_ready_pulse: assert property (pready_out |=> !pready_out)
      else $error("pready too long");
   a_err_ready: assert property (pslverr_out |-> pready_out)
      else $error("pslverr without pready");
   a_strobe_sel: assert property ((!flash_we_n_out || !flash_oe_n_out) |->
      !flash_ce_n_out) else $error("strobe without select");
   a_we_width: assert property ($fell(flash_we_n_out) |=> flash_we_n_out)
      else $error("write strobe width");
   a_read_len: assert property ($fell(flash_oe_n_out) |->
      !flash_oe_n_out [*3] ##1 flash_oe_n_out) else $error("read len");
   a_addr_hold: assert property (!flash_ce_n_out && !$past(flash_ce_n_out)
      |-> $stable(flash_addr_out) && $stable(flash_dq_out))
      else $error("addr or data moved");
   a_release_rd: assert property (!flash_oe_n_out |-> !flash_dq_oe_out)
      else $error("dq driven in read");
   a_upper_zero: assert property (!flash_we_n_out && flash_byte_n_out |->
      flash_dq_out[15:8] == 8'h00) else $error("upper byte set");
endmodule : nbp_host_sva
bind nbp_host_top nbp_host_sva chk (.*);

/* dv/nbp_flash_model.sv */
`timescale 1ns/1ps
module nbp_flash_model (
   // Flash pins from the host
   input wire logic ce_n_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   input wire logic [nbp_pkg::ADDR_W-1:0] addr_in,
   input wire logic [nbp_pkg::DQ_W-1:0] dq_in,
   // Data back to the host
   output logic [nbp_pkg::DQ_W-1:0] dq_out
);
   logic [nbp_pkg::ADDR_W-1:0] la[$];
   logic [7:0] ld[$];
   logic [7:0] mode = 8'h00;
   logic [15:0] lockreg = 16'hFFFF;
   logic [15:0] pw[8];
   logic [15:0] rv;
   logic [15:0] last = 16'h0000;
   logic nvb = 1'b1, vb = 1'b1, lkb = 1'b1;
   always @(posedge we_n_in) if (!ce_n_in) begin
      if (ld.size() > 1 && ld[$] == 8'h55 && ld[$-1] == 8'hAA)
         mode = dq_in[7:0];
      else if (ld.size() > 0 && ld[$] == 8'hA0 && mode == 8'h40)
         lockreg = dq_in;
      else if (ld.size() > 0 && ld[$] == 8'hA0 && mode == 8'h60)
         pw[addr_in[2:0]] = dq_in;
      else if (ld.size() > 0 && ld[$] == 8'hA0) begin
         if (mode == 8'hC0) nvb = dq_in[0];
         if (mode == 8'hE0) vb = dq_in[0];
         if (mode == 8'h50) lkb = 1'b0;
      end else if (ld.size() > 0 && ld[$] == 8'h80 && dq_in[7:0] == 8'h30)
         nvb = nvb | lkb;
      else if (ld.size() > 0 && ld[$] == 8'h90 && dq_in[7:0] == 8'h00)
         mode = 8'h00;
      la.push_back(addr_in);
      ld.push_back(dq_in[7:0]);
   end
   always_comb rv = (mode == 8'h40) ? lockreg :
      (mode == 8'h60) ? pw[addr_in[2:0]] :
      (mode == 8'hC0) ? {15'h0, nvb} :
      (mode == 8'hE0) ? {15'h0, nvb & vb} :
      (mode == 8'h50) ? {15'h0, lkb} :
      (mode != 8'h00 && addr_in[24:17] == 8'h00) ? 16'hFFFF : 16'h0001;
   always @(posedge oe_n_in) last <= rv;
   assign dq_out = (!ce_n_in && !oe_n_in) ? rv : ~last;
endmodule : nbp_flash_model

/* dv/nbp_host_top_bench.sv */
`timescale 1ns/1ps
module nbp_host_top_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] pa = 8'h00;
   logic [31:0] pwd = 32'h0000_0000;
   logic [31:0] prd, q, st;
   logic rdy, serr, se, ce_n, oe_n, we_n, byte_n, dq_oe;
   logic [24:0] fa;
   logic [15:0] hdq, mdq, wdq;
   logic [7:0] codes[6] = '{8'h40, 8'h60, 8'hC0, 8'h50, 8'hE0, 8'h88};
   int fails = 0;
   int n_checks = 0;
   logic skip = 1'b0;
   always #50 clk = ~clk;
   assign wdq = dq_oe ? hdq : mdq;
   nbp_host_top dut (.sys_clk_in(clk), .sys_rst_in(rst), .ce_in(1'b1),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
      .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
      .pslverr_out(serr), .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n),
      .flash_we_n_out(we_n), .flash_byte_n_out(byte_n),
      .flash_addr_out(fa), .flash_dq_out(hdq), .flash_dq_oe_out(dq_oe),
      .flash_dq_in(wdq));
   nbp_flash_model fm (.ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
      .addr_in(fa), .dq_in(wdq), .dq_out(mdq));
   task automatic wrap_up;
      if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   task automatic limit(input int n, input int m);
      if (n >= m) begin
         fails++;
         wrap_up();
      end
   endtask : limit
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         fails++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   task automatic chkw(input int i, input logic [24:0] a, input logic [7:0] d);
      chk("addr", 32'(a), 32'(fm.la[i]));
      chk("data", 32'(d), 32'(fm.ld[i]));
   endtask : chkw
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      q = prd;
      se = serr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
      limit(n, 20);
   endtask : apb
   task automatic run(input int c, input logic w);
      int n;
      n = 0;
      fm.la.delete();
      fm.ld.delete();
      apb(1'b1, nbp_pkg::OFF_CTRL, 32'h0000_0100 | (32'(w) << 4) | 32'(c));
      do begin
         apb(1'b0, nbp_pkg::OFF_STATUS, 32'h0000_0000);
         n++;
      end while (q[2:1] === 2'b00 && n < 60);
      st = q;
      if (!skip) apb(1'b1, nbp_pkg::OFF_STATUS, 32'h0000_0006);
      limit(n, 60);
   endtask : run
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("reset", 32'h0000_0001, {30'h0, rdy, ce_n});
      for (int k = 0; k < 6; k++) begin
         run(k, 1'b0);
         chkw(0, nbp_pkg::A_BYTE_U1, 8'hAA);
         chkw(1, nbp_pkg::A_BYTE_U2, 8'h55);
         chkw(2, nbp_pkg::A_BYTE_U1, codes[k]);
         run(k == 5 ? 7 : 6, 1'b0);
         chk("exit", 32'h0000_9000, {fm.ld[$-1], fm.ld[$]});
      end
      run(0, 1'b1);
      chkw(1, nbp_pkg::A_WORD_U2, 8'h55);
      chkw(2, nbp_pkg::A_WORD_U1, 8'h40);
      apb(1'b1, nbp_pkg::OFF_DATA, 32'h0000_00A5);
      run(8, 1'b1);
      chk("lockprog", 32'h0000_A0A5, {fm.ld[0], fm.ld[1]});
      run(9, 1'b1);
      apb(1'b0, nbp_pkg::OFF_RDATA, 32'h0000_0000);
      chk("lockread", 32'h0000_00A5, q & 32'h0000_00FF);
      run(6, 1'b1);
      run(2, 1'b0);
      apb(1'b1, nbp_pkg::OFF_DATA, 32'h0000_0000);
      run(8, 1'b0);
      chkw(1, 25'h000_0000, 8'h00);
      run(9, 1'b0);
      chk("nvprot", 32'h0000_0008, st & 32'h0000_0008);
      run(10, 1'b0);
      chkw(1, 25'h000_0000, 8'h30);
      run(9, 1'b0);
      chk("nvfree", 32'h0000_0000, st & 32'h0000_0008);
      run(6, 1'b0);
      run(1, 1'b0);
      for (int i = 7; i >= 0; i--) begin
         apb(1'b1, nbp_pkg::OFF_ADDR, 32'(i));
         apb(1'b1, nbp_pkg::OFF_DATA, 32'h0000_0010 + 32'(i));
         apb(1'b1, nbp_pkg::OFF_PWD + 8'(4 * i), 32'h0000_0010 + 32'(i));
         run(8, 1'b0);
         chk("pwprog", {8'(i), 24'hA0_0010 + 24'(i)},
            {fm.la[1][7:0], fm.ld[0], 8'h00, fm.ld[1]});
      end
      apb(1'b1, nbp_pkg::OFF_ADDR, 32'h0000_0005);
      run(9, 1'b0);
      apb(1'b0, nbp_pkg::OFF_RDATA, 32'h0000_0000);
      chk("pwread", 32'h0000_0015, q & 32'h0000_00FF);
      skip = 1'b1;
      run(11, 1'b0);
      skip = 1'b0;
      chkw(0, 25'h000_0000, 8'h25);
      chkw(1, 25'h000_0000, 8'h03);
      for (int i = 0; i < 8; i++) chkw(i + 2, 25'(i), 8'h10 + 8'(i));
      chkw(10, 25'h000_0000, 8'h29);
      run(11, 1'b0);
      chk("spacing", 32'h0000_0006, st & 32'h0000_0007);
      chk("refused", 32'h0000_0000, 32'(fm.ld.size()));
      run(12, 1'b0);
      chk("badcmd", 32'h0000_0004, st & 32'h0000_0006);
      run(11, 1'b1);
      chkw(5, 25'h000_0003, 8'h13);
      chkw(6, 25'h000_0000, 8'h29);
      run(6, 1'b0);
      apb(1'b0, 8'h44, 32'h0000_0000);
      chk("unmapped", 32'h0000_0001, 32'(se));
      wrap_up();
   end
endmodule : nbp_host_top_bench
